// ==== pxr_consts.vh ====
// Register offsets, field positions, reset values and timing counts for the proximity block
`ifndef PXR_CONSTS_VH
`define PXR_CONSTS_VH
`define PXR_CLK_HZ         10000000
`define PXR_CMD_CONF1      8'h00
`define PXR_CMD_CONF2      8'h01
`define PXR_CMD_CONF3      8'h02
`define PXR_CMD_THLO       8'h03
`define PXR_CMD_THHI       8'h04
`define PXR_CMD_CANC       8'h05
`define PXR_CMD_DATA       8'hF8
`define PXR_CMD_FLAGS      8'hF9
`define PXR_CMD_IDENT      8'hFA
`define PXR_ADDR_STRAIGHT  7'h60
`define PXR_ADDR_SWAPPED   7'h51
`define PXR_ID_LO_STRAIGHT 8'h5A
`define PXR_ID_LO_SWAPPED  8'h5B
`define PXR_ID_HI          8'hA7
`define PXR_WORD_RESET     16'h0000
`define PXR_B_POWER        0
`define PXR_B_CAL          7
`define PXR_B_FASTPERS     12
`define PXR_B_GLARE_IE     13
`define PXR_B_WIDE         14
`define PXR_B_GAIN         0
`define PXR_B_UNIT         1
`define PXR_B_FORCED       4
`define PXR_B_TRIG         5
`define PXR_B_GLARE_F      12
`define PXR_B_NEAR_F       9
`define PXR_B_FAR_F        8
`define PXR_MASK_CONF1     16'h7F81
`define PXR_MASK_CONF2     16'h37FF
`define PXR_MASK_CONF3     16'hDC30
`define PXR_MASK_CANC      16'h0FFF
`define PXR_MS_UNIT        10000
`define PXR_P_50MS         50
`define PXR_P_100MS        100
`define PXR_P_200MS        200
`define PXR_P_400MS        400
`define PXR_SP_6P25_US     6250
`define PXR_SP_12P5_US     12500
`define PXR_SP_25_US       25000
`define PXR_T_SHORT_US     25
`define PXR_T_LONG_US      50
`define PXR_US_CYC         (`PXR_CLK_HZ / 1000000)
`define PXR_MAX12          16'h0FFF
`endif

// ==== pxr_host_model.sv ====
// Host-side two-wire master model for the sensor bus
`timescale 1ns/1ns
`include "pxr_consts.vh"
module pxr_host_model
(
	// Clock
	input  wire mclk_i,
	// Wire levels and pull-down enables
	input  wire scl_i,
	input  wire sda_i,
	output reg  scl_oe_o,
	output reg  sda_oe_o
);
	// Ten cycles a phase; the device syncs pins through three flops
	localparam int H = 10;
	initial
	begin
		scl_oe_o = 1'h0;
		sda_oe_o = 1'h0;
	end
	task automatic hold(input logic scl, input logic sda);
	begin
		scl_oe_o <= ~scl;
		sda_oe_o <= ~sda;
		repeat (H) @(posedge mclk_i);
	end
	endtask
	task automatic start();
	begin
		// Data falls first at idle, so the strap reads straight
		if (scl_oe_o)
			hold(1'h0, 1'h1);
		hold(1'h1, 1'h1);
		hold(1'h1, 1'h0);
		hold(1'h0, 1'h0);
	end
	endtask
	task automatic stop();
	begin
		hold(1'h0, 1'h0);
		hold(1'h1, 1'h0);
		hold(1'h1, 1'h1);
	end
	endtask
	task automatic bitx(input logic b, output logic r);
	begin
		hold(1'h0, b);
		hold(1'h1, b);
		r = sda_i;
		hold(1'h0, b);
	end
	endtask
	task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] r,
		output logic nak);
		int i;
	begin
		for (i = 7; i >= 0; i--)
			bitx(d[i], r[i]);
		bitx(ak, nak);
	end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
		output logic nak);
		logic [7:0] r;
		logic       n0, n1, n2, n3;
	begin
		start();
		xfer({a, 1'h0}, 1'h1, r, n0);
		xfer(c, 1'h1, r, n1);
		xfer(d[7:0], 1'h1, r, n2);
		xfer(d[15:8], 1'h1, r, n3);
		stop();
		nak = n0 | n1 | n2 | n3;
	end
	endtask
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		logic [7:0] r;
		logic       n;
	begin
		start();
		xfer({`PXR_ADDR_STRAIGHT, 1'h0}, 1'h1, r, n);
		xfer(c, 1'h1, r, n);
		start();
		xfer({`PXR_ADDR_STRAIGHT, 1'h1}, 1'h1, r, n);
		xfer(8'hFF, 1'h0, d[7:0], n);
		xfer(8'hFF, 1'h1, d[15:8], n);
		stop();
	end
	endtask
endmodule

// ==== pxr_sensor_regs.v ====
// I2C register file and measurement sequencer of the proximity sensor
//
// Operation
// - Bit 0 powers sensor; reset shut down
// - Bit 7 enables internal calibration
// - Bit 14 picks 12 bit output, or 12-16 bit set by time and gain
// - Glare event sets flag bit 12
// - Bit 12 enables fast persistence after event
// - Bits 11:10 set crossings needed, 1-4
// - Bits 9:8 pick interrupt mode
// - Integration length and pulse count fields
// - Bit 1 picks 25 or 50 us unit
// - Output saturates per resolution, time, gain
// - Crosstalk cancel and high sensitivity bits
// - Bits 10:8 select emitter current
// - Forced mode trigger self-clears after measurement
// - Short period codes override normal period
// - Sunlight cancel field, 000 off, 111 on
// - Sixteen-bit thresholds compared, reset zero
// - Twelve-bit offset subtracted, top bits zero
// - Data word returns latest result
// - Near and far crossing flags bits 9, 8
// - Identity low byte follows address strap
// - Address 0x60 straight, 0x51 swapped pins
`timescale 1ns/1ns
`include "pxr_consts.vh"
module pxr_sensor_regs
(
	// Clock and reset
	input  wire        mclk_i,
	input  wire        rstn_i,
	// Two-wire bus pins, pin A and pin B
	input  wire        pin_a_i,
	output wire        pin_a_o,
	output wire        pin_a_oe_o,
	input  wire        pin_b_i,
	output wire        pin_b_o,
	output wire        pin_b_oe_o,
	// Analog front end
	input  wire [15:0] raw_count_i,
	input  wire        glare_event_i,
	output reg         meas_start_o,
	output wire [2:0]  emitter_current_o,
	output wire [1:0]  pulse_count_o,
	output wire        calibration_enable_o,
	output wire        high_sensitivity_o,
	output wire        crosstalk_cancel_o,
	output wire        ambient_cancel_o,
	// Interrupt pin, open drain
	output wire        irq_o,
	output wire        irq_oe_o
);
	localparam ST_IDLE = 3'd0;
	localparam ST_ADDR = 3'd1;
	localparam ST_CMD  = 3'd2;
	localparam ST_WDAT = 3'd3;
	localparam ST_RDAT = 3'd4;
	localparam ST_SKIP = 3'd5;
	localparam M_WAIT  = 2'd0;
	localparam M_INTEG = 2'd1;

	// Three-stage pin synchronisers
	reg [2:0] a_sync_q;
	reg [2:0] b_sync_q;
	reg       a_q;
	reg       b_q;
	always @(posedge mclk_i)
	begin
		a_sync_q <= {a_sync_q[1:0], pin_a_i};
		b_sync_q <= {b_sync_q[1:0], pin_b_i};
		if (!rstn_i)
		begin
			a_q <= 1'b1;
			b_q <= 1'b1;
		end
		else
		begin
			if (a_sync_q[1] == a_sync_q[2])
				a_q <= a_sync_q[2];
			if (b_sync_q[1] == b_sync_q[2])
				b_q <= b_sync_q[2];
		end
	end

	// Strap: the first pin to fall marks data (start condition), so it picks roles
	reg swap_q;
	reg strap_done_q;
	always @(posedge mclk_i)
	begin
		if (!rstn_i)
		begin
			swap_q       <= 1'b0;
			strap_done_q <= 1'b0;
		end
		else if (!strap_done_q && (!a_q || !b_q))
		begin
			swap_q       <= a_q & ~b_q;
			strap_done_q <= 1'b1;
		end
	end
	wire scl = swap_q ? a_q : b_q;
	wire sda = swap_q ? b_q : a_q;
	wire [6:0] own_addr = swap_q ? `PXR_ADDR_SWAPPED : `PXR_ADDR_STRAIGHT;

	// Delay the raw pins, so a strap decision never fakes an edge
	reg a_d_q;
	reg b_d_q;
	always @(posedge mclk_i)
	begin
		a_d_q <= a_q;
		b_d_q <= b_q;
	end
	wire scl_q    = swap_q ? a_d_q : b_d_q;
	wire sda_q    = swap_q ? b_d_q : a_d_q;
	wire scl_rise = scl & ~scl_q;
	wire scl_fall = ~scl & scl_q;
	// The very first fall is the first start, before roles are known
	wire first_start = ~strap_done_q & (a_q ^ b_q);
	wire start_c  = first_start | (strap_done_q & scl & scl_q & sda_q & ~sda);
	wire stop_c   = strap_done_q & scl & scl_q & ~sda_q & sda;

	// Registers
	reg [15:0] conf1_q;
	reg [15:0] conf2_q;
	reg [15:0] conf3_q;
	reg [15:0] thlo_q;
	reg [15:0] thhi_q;
	reg [15:0] canc_q;
	reg [15:0] data_q;
	reg        glare_f_q;
	reg        near_f_q;
	reg        far_f_q;

	// Bus engine
	reg [2:0]  st_q;
	reg [3:0]  bit_q;
	reg [7:0]  sh_q;
	reg [7:0]  cmd_q;
	reg        hi_q;
	reg        rd_q;
	reg        ack_q;
	reg        drv_q;
	reg [7:0]  lo_byte_q;
	reg [15:0] rd_word_q;
	reg        flags_rd_q;
	reg        wr_stb_q;

	function [15:0] reg_read;
		input [7:0] c;
		begin
			reg_read = 16'h0000;
			if (c == `PXR_CMD_CONF1)
				reg_read = conf1_q;
			else if (c == `PXR_CMD_CONF2)
				reg_read = conf2_q;
			else if (c == `PXR_CMD_CONF3)
				reg_read = conf3_q;
			else if (c == `PXR_CMD_THLO)
				reg_read = thlo_q;
			else if (c == `PXR_CMD_THHI)
				reg_read = thhi_q;
			else if (c == `PXR_CMD_CANC)
				reg_read = canc_q;
			else if (c == `PXR_CMD_DATA)
				reg_read = data_q;
			else if (c == `PXR_CMD_FLAGS)
				reg_read = {3'b000, glare_f_q, 2'b00, near_f_q, far_f_q, 8'h00};
			else if (c == `PXR_CMD_IDENT)
				reg_read = {`PXR_ID_HI, swap_q ? `PXR_ID_LO_SWAPPED : `PXR_ID_LO_STRAIGHT};
		end
	endfunction
	wire [15:0] rd_now = reg_read(cmd_q);

	always @(posedge mclk_i)
	begin
		if (!rstn_i)
		begin
			st_q       <= ST_IDLE;
			bit_q      <= 4'd0;
			sh_q       <= 8'h00;
			cmd_q      <= 8'h00;
			hi_q       <= 1'b0;
			rd_q       <= 1'b0;
			ack_q      <= 1'b0;
			drv_q      <= 1'b0;
			lo_byte_q  <= 8'h00;
			rd_word_q  <= 16'h0000;
			flags_rd_q <= 1'b0;
			wr_stb_q   <= 1'b0;
		end
		else
		begin
			flags_rd_q <= 1'b0;
			wr_stb_q   <= 1'b0;
			if (start_c)
			begin
				// Repeated start keeps the command code for the read
				st_q  <= ST_ADDR;
				bit_q <= 4'd0;
				ack_q <= 1'b0;
				drv_q <= 1'b0;
			end
			else if (stop_c)
			begin
				st_q  <= ST_IDLE;
				drv_q <= 1'b0;
			end
			else if (scl_rise && !ack_q && st_q != ST_IDLE && st_q != ST_SKIP)
			begin
				sh_q  <= {sh_q[6:0], sda};
				bit_q <= bit_q + 4'd1;
			end
			else if (scl_fall && st_q != ST_IDLE && st_q != ST_SKIP)
			begin
				if (ack_q)
				begin
					// End of acknowledge slot
					ack_q <= 1'b0;
					bit_q <= 4'd0;
					drv_q <= 1'b0;
					if (st_q == ST_RDAT)
						drv_q <= ~rd_word_q[15];
				end
				else if (st_q == ST_RDAT)
				begin
					if (bit_q == 4'd8)
					begin
						// Master ack slot: release; the ack bit is not sampled, high byte follows the low one, then skip
						drv_q <= 1'b0;
						ack_q <= 1'b1;
						hi_q  <= ~hi_q;
						// Eighth rotation brings the high byte's top bit up
						rd_word_q <= {rd_word_q[14:0], rd_word_q[15]};
						if (hi_q)
							st_q <= ST_SKIP;
					end
					else
					begin
						drv_q     <= ~rd_word_q[14];
						rd_word_q <= {rd_word_q[14:0], rd_word_q[15]};
					end
				end
				else if (bit_q == 4'd8)
				begin
					ack_q <= 1'b1;
					drv_q <= 1'b1;
					if (st_q == ST_ADDR)
					begin
						if (sh_q[7:1] != own_addr)
						begin
							st_q  <= ST_SKIP;
							ack_q <= 1'b0;
							drv_q <= 1'b0;
						end
						else if (sh_q[0])
						begin
							// Low byte first, shifted MSB first
							st_q      <= ST_RDAT;
							hi_q      <= 1'b0;
							rd_word_q <= {rd_now[7:0], rd_now[15:8]};
							if (cmd_q == `PXR_CMD_FLAGS)
								flags_rd_q <= 1'b1;
						end
						else
							st_q <= ST_CMD;
					end
					else if (st_q == ST_CMD)
					begin
						cmd_q <= sh_q;
						hi_q  <= 1'b0;
						st_q  <= ST_WDAT;
					end
					else
					begin
						if (!hi_q)
							lo_byte_q <= sh_q;
						else
							wr_stb_q <= 1'b1;
						hi_q <= ~hi_q;
					end
				end
			end
		end
	end

	// Register writes; a lone low byte is dropped
	wire [15:0] wr_word = {sh_q, lo_byte_q};
	reg         meas_done_q;
	always @(posedge mclk_i)
	begin
		if (!rstn_i)
		begin
			conf1_q <= `PXR_WORD_RESET;
			conf2_q <= `PXR_WORD_RESET;
			conf3_q <= `PXR_WORD_RESET;
			thlo_q  <= `PXR_WORD_RESET;
			thhi_q  <= `PXR_WORD_RESET;
			canc_q  <= `PXR_WORD_RESET;
		end
		else
		begin
			if (wr_stb_q && cmd_q == `PXR_CMD_CONF1)
				conf1_q <= wr_word & `PXR_MASK_CONF1;
			if (wr_stb_q && cmd_q == `PXR_CMD_CONF2)
				conf2_q <= wr_word & `PXR_MASK_CONF2;
			if (wr_stb_q && cmd_q == `PXR_CMD_CONF3)
				conf3_q <= wr_word & `PXR_MASK_CONF3;
			else if (meas_done_q && conf3_q[`PXR_B_FORCED])
				conf3_q[`PXR_B_TRIG] <= 1'b0;
			if (wr_stb_q && cmd_q == `PXR_CMD_THLO)
				thlo_q <= wr_word;
			if (wr_stb_q && cmd_q == `PXR_CMD_THHI)
				thhi_q <= wr_word;
			if (wr_stb_q && cmd_q == `PXR_CMD_CANC)
				canc_q <= wr_word & `PXR_MASK_CANC;
		end
	end

	// Field outputs to the front end
	assign calibration_enable_o = conf1_q[`PXR_B_CAL];
	assign emitter_current_o    = conf2_q[10:8];
	assign pulse_count_o        = conf2_q[3:2];
	assign high_sensitivity_o   = conf2_q[13];
	assign crosstalk_cancel_o   = conf2_q[12];
	assign ambient_cancel_o     = &conf3_q[12:10];

	// Measurement timing in us, then microsecond tick
	localparam [31:0] US_LAST = `PXR_US_CYC - 1;
	localparam [31:0] PER0    = `PXR_P_50MS * 1000;
	localparam [31:0] PER1    = `PXR_P_100MS * 1000;
	localparam [31:0] PER2    = `PXR_P_200MS * 1000;
	localparam [31:0] PER3    = `PXR_P_400MS * 1000;
	localparam [31:0] SPER1   = `PXR_SP_6P25_US;
	localparam [31:0] SPER2   = `PXR_SP_12P5_US;
	localparam [31:0] SPER3   = `PXR_SP_25_US;
	localparam [31:0] T_SHORT = `PXR_T_SHORT_US;
	localparam [31:0] T_LONG  = `PXR_T_LONG_US;
	reg [3:0]  us_div_q;
	wire       us_tick = (us_div_q == US_LAST[3:0]);
	reg [18:0] per_us;
	always @*
	begin
		case (conf3_q[15:14])
			2'd1: per_us = SPER1[18:0];
			2'd2: per_us = SPER2[18:0];
			2'd3: per_us = SPER3[18:0];
			default:
			begin
				case (conf2_q[7:6])
					2'd0: per_us = PER0[18:0];
					2'd1: per_us = PER1[18:0];
					2'd2: per_us = PER2[18:0];
					default: per_us = PER3[18:0];
				endcase
			end
		endcase
	end
	// Integration: unit times 1,2,4,8 times pulse count
	wire [5:0]  unit_us = conf2_q[`PXR_B_UNIT] ? T_LONG[5:0] : T_SHORT[5:0];
	wire [12:0] integ_us = ({7'd0, unit_us} << conf2_q[5:4]) << conf2_q[3:2];

	// Saturation ceiling
	wire [4:0]  res_bits = !conf1_q[`PXR_B_WIDE] ? 5'd12
		: 5'd12 + {3'd0, conf2_q[5:4]} + {4'd0, conf2_q[`PXR_B_GAIN]};
	wire [16:0] ceil_w = (17'd1 << res_bits) - 17'd1;
	wire [15:0] ceil = ceil_w[15:0];
	wire [15:0] canc_v = {4'h0, canc_q[11:0]};
	wire [15:0] net_v = (raw_count_i > canc_v) ? raw_count_i - canc_v : 16'h0000;
	wire [15:0] result = (net_v > ceil) ? ceil : net_v;

	reg [1:0]  m_st_q;
	reg [18:0] m_cnt_q;
	always @(posedge mclk_i)
	begin
		if (!rstn_i)
		begin
			us_div_q     <= 4'd0;
			m_st_q       <= M_WAIT;
			m_cnt_q      <= 19'd0;
			meas_start_o <= 1'b0;
			meas_done_q  <= 1'b0;
			data_q       <= 16'h0000;
		end
		else
		begin
			us_div_q     <= us_tick ? 4'd0 : us_div_q + 4'd1;
			meas_start_o <= 1'b0;
			meas_done_q  <= 1'b0;
			case (m_st_q)
				M_WAIT:
				begin
					if (!conf1_q[`PXR_B_POWER])
						m_cnt_q <= 19'd0;
					// Trigger still reads set in the cycle it is cleared
					else if (conf3_q[`PXR_B_FORCED] ? (conf3_q[`PXR_B_TRIG] & ~meas_done_q)
						: (us_tick && m_cnt_q >= per_us - 19'd1))
					begin
						m_cnt_q      <= 19'd0;
						meas_start_o <= 1'b1;
						m_st_q       <= M_INTEG;
					end
					else if (us_tick && !conf3_q[`PXR_B_FORCED])
						m_cnt_q <= m_cnt_q + 19'd1;
				end
				default:
				begin
					if (us_tick)
						m_cnt_q <= m_cnt_q + 19'd1;
					if (us_tick && m_cnt_q >= {6'd0, integ_us} - 19'd1)
					begin
						data_q      <= result;
						meas_done_q <= 1'b1;
						m_cnt_q     <= 19'd0;
						m_st_q      <= M_WAIT;
					end
				end
			endcase
		end
	end

	// Threshold evaluation with persistence
	reg [1:0] hi_cnt_q;
	reg [1:0] lo_cnt_q;
	reg       fired_q;
	reg       state_hi_q;
	wire      above = data_q > thhi_q;
	wire      below = data_q < thlo_q;
	wire      fast_pers = conf1_q[`PXR_B_FASTPERS] & fired_q;
	wire [1:0] need = (fast_pers) ? 2'd0 : conf1_q[11:10];
	wire [1:0] mode = conf1_q[9:8];
	wire      near_hit = meas_done_q && above && hi_cnt_q >= need;
	wire      far_hit  = meas_done_q && below && lo_cnt_q >= need;
	// Mode 2 arms low events only after the first high event
	wire      near_ev = near_hit && (mode == 2'd3 || mode == 2'd2
		|| (mode == 2'd1 && !state_hi_q));
	wire      far_ev  = far_hit && (mode == 2'd3 || (mode == 2'd2 && fired_q)
		|| (mode == 2'd1 && state_hi_q));
	always @(posedge mclk_i)
	begin
		if (!rstn_i)
		begin
			hi_cnt_q   <= 2'd0;
			lo_cnt_q   <= 2'd0;
			fired_q    <= 1'b0;
			state_hi_q <= 1'b0;
			glare_f_q  <= 1'b0;
			near_f_q   <= 1'b0;
			far_f_q    <= 1'b0;
		end
		else
		begin
			if (meas_done_q)
			begin
				hi_cnt_q <= (above && hi_cnt_q != 2'd3) ? hi_cnt_q + 2'd1 : (above ? hi_cnt_q : 2'd0);
				lo_cnt_q <= (below && lo_cnt_q != 2'd3) ? lo_cnt_q + 2'd1 : (below ? lo_cnt_q : 2'd0);
			end
			if (near_ev)
				state_hi_q <= 1'b1;
			else if (far_ev)
				state_hi_q <= 1'b0;
			if (near_ev || far_ev)
				fired_q <= 1'b1;
			// Set wins over the clear-on-read
			if (flags_rd_q)
			begin
				glare_f_q <= 1'b0;
				near_f_q  <= 1'b0;
				far_f_q   <= 1'b0;
			end
			if (glare_event_i && conf1_q[`PXR_B_GLARE_IE])
				glare_f_q <= 1'b1;
			if (near_ev)
				near_f_q <= 1'b1;
			if (far_ev)
				far_f_q <= 1'b1;
		end
	end

	// Logic mode holds pin low while near; others while any flag is set
	wire irq_act = (mode == 2'd1) ? state_hi_q : (glare_f_q | near_f_q | far_f_q);
	assign irq_o    = 1'b0;
	assign irq_oe_o = irq_act;
	assign pin_a_o    = 1'b0;
	assign pin_b_o    = 1'b0;
	assign pin_a_oe_o = drv_q & ~swap_q;
	assign pin_b_oe_o = drv_q & swap_q;
endmodule

// ==== pxr_sensor_regs_props.sv ====
// Port-level assertions for the proximity register block
`timescale 1ns/1ns
module pxr_sensor_regs_props
(
	// Clock and reset
	input wire       mclk_i,
	input wire       rstn_i,
	// Bus pins
	input wire       pin_b_i,
	input wire       pin_a_o,
	input wire       pin_a_oe_o,
	input wire       pin_b_o,
	input wire       pin_b_oe_o,
	// Front end and interrupt
	input wire       meas_start_o,
	input wire [2:0] emitter_current_o,
	input wire [1:0] pulse_count_o,
	input wire       calibration_enable_o,
	input wire       high_sensitivity_o,
	input wire       crosstalk_cancel_o,
	input wire       ambient_cancel_o,
	input wire       irq_o,
	input wire       irq_oe_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rstn_i);

	a_reset_quiet: assert property (disable iff (1'h0)
		!rstn_i |=> !irq_oe_o && !meas_start_o && !pin_a_oe_o && !pin_b_oe_o)
		else $error("outputs active after reset");
	a_drive_low_only: assert property (!pin_a_o && !pin_b_o && !irq_o)
		else $error("open drain output driven high");
	a_clock_pin_free: assert property (!pin_b_oe_o)
		else $error("clock pin pulled by device");
	a_data_moves_low: assert property ($changed(pin_a_oe_o) |-> !pin_b_i)
		else $error("data pin changed while clock high");
	a_data_released: assert property ($rose(pin_a_oe_o) |-> ##[1:1000] !pin_a_oe_o)
		else $error("data pin held too long");
	a_start_single: assert property (meas_start_o |=> !meas_start_o [*8])
		else $error("measurement start repeated");
	a_field_on_write: assert property (!$stable({emitter_current_o, pulse_count_o,
		calibration_enable_o, high_sensitivity_o, crosstalk_cancel_o, ambient_cancel_o})
		|-> !pin_b_i)
		else $error("field changed outside a stored byte");
	a_irq_clear_bus: assert property ($fell(irq_oe_o) |-> pin_a_oe_o)
		else $error("interrupt released outside a flag read");
endmodule
bind pxr_sensor_regs pxr_sensor_regs_props i_props (.mclk_i(mclk_i), .rstn_i(rstn_i),
	.pin_b_i(pin_b_i), .pin_a_o(pin_a_o), .pin_a_oe_o(pin_a_oe_o), .pin_b_o(pin_b_o),
	.pin_b_oe_o(pin_b_oe_o), .meas_start_o(meas_start_o),
	.emitter_current_o(emitter_current_o), .pulse_count_o(pulse_count_o),
	.calibration_enable_o(calibration_enable_o), .high_sensitivity_o(high_sensitivity_o),
	.crosstalk_cancel_o(crosstalk_cancel_o), .ambient_cancel_o(ambient_cancel_o),
	.irq_o(irq_o), .irq_oe_o(irq_oe_o));

// ==== pxr_sensor_regs_test.sv ====
// Self-checking bench for the proximity register block
`timescale 1ns/1ns
`include "pxr_consts.vh"
module pxr_sensor_regs_test;
	logic        mclk_i = 1'h0;
	logic        rstn_i = 1'h0;
	logic [15:0] raw_count_i = 16'h0000;
	logic        glare_event_i = 1'h0;
	wire         pin_a_o, pin_a_oe_o, pin_b_o, pin_b_oe_o, meas_start_o, irq_o, irq_oe_o;
	wire         calibration_enable_o, high_sensitivity_o, crosstalk_cancel_o;
	wire         ambient_cancel_o, scl_oe, sda_oe, sda, scl;
	wire [2:0]   emitter_current_o;
	wire [1:0]   pulse_count_o;
	int          n_mismatch = 0;
	int          checked = 0;
	int          starts = 0;
	int          i;
	logic [15:0] v;
	logic [2:0]  c;
	logic        nak;
	// Both lines pulled up; any party may pull low
	assign sda = ~(sda_oe | pin_a_oe_o);
	assign scl = ~(scl_oe | pin_b_oe_o);
	always #50 mclk_i = ~mclk_i;
	always @(posedge mclk_i)
		if (meas_start_o)
			starts <= starts + 1;
	pxr_sensor_regs i_pxr_sensor_regs (.mclk_i(mclk_i), .rstn_i(rstn_i), .pin_a_i(sda),
		.pin_a_o(pin_a_o), .pin_a_oe_o(pin_a_oe_o), .pin_b_i(scl), .pin_b_o(pin_b_o),
		.pin_b_oe_o(pin_b_oe_o), .raw_count_i(raw_count_i), .glare_event_i(glare_event_i),
		.meas_start_o(meas_start_o), .emitter_current_o(emitter_current_o),
		.pulse_count_o(pulse_count_o), .calibration_enable_o(calibration_enable_o),
		.high_sensitivity_o(high_sensitivity_o), .crosstalk_cancel_o(crosstalk_cancel_o),
		.ambient_cancel_o(ambient_cancel_o), .irq_o(irq_o), .irq_oe_o(irq_oe_o));
	pxr_host_model host (.mclk_i(mclk_i), .scl_i(scl), .sda_i(sda), .scl_oe_o(scl_oe),
		.sda_oe_o(sda_oe));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
	begin
		checked++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [15:0] d);
	begin
		host.wr(`PXR_ADDR_STRAIGHT, a, d, nak);
		chk($sformatf("ack %h", a), 16'h0000, {15'h0000, nak});
	end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [15:0] e);
	begin
		host.rd(a, v);
		chk($sformatf("reg %h", a), e, v);
	end
	endtask
	// Forced mode single shot; the trigger bit is polled until it self-clears
	task automatic meas(input logic [15:0] c1, input logic [15:0] c2,
		input logic [15:0] cn, input logic [15:0] raw, input logic [15:0] e);
		int s, k;
	begin
		s = starts;
		wrr(`PXR_CMD_CANC, cn);
		wrr(`PXR_CMD_CONF2, c2);
		wrr(`PXR_CMD_CONF1, c1);
		raw_count_i <= raw;
		wrr(`PXR_CMD_CONF3, 16'h0030);
		v = 16'h0030;
		for (k = 0; k < 8 && v !== 16'h0010; k++)
			host.rd(`PXR_CMD_CONF3, v);
		chk("trigger", 16'h0010, v);
		chk("starts", 16'h0001, 16'(starts - s));
		rdc(`PXR_CMD_DATA, e);
	end
	endtask
	task automatic results();
	begin
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		repeat (95000) @(posedge mclk_i);
		n_mismatch++;
		results();
	end
	initial
	begin
		repeat (4) @(posedge mclk_i);
		rstn_i <= 1'h1;
		repeat (4) @(posedge mclk_i);
		host.wr(`PXR_ADDR_SWAPPED, `PXR_CMD_CONF1, 16'h0001, nak);
		chk("foreign address", 16'h0001, {15'h0000, nak});
		wrr(8'h10, 16'hFFFF);
		for (i = 0; i < 6; i++)
			rdc(8'(i), 16'h0000);
		rdc(`PXR_CMD_IDENT, {`PXR_ID_HI, `PXR_ID_LO_STRAIGHT});
		rdc(`PXR_CMD_FLAGS, 16'h0000);
		$display("test reset values done");
		for (i = 0; i < 8; i++)
		begin
			c = i[2:0];
			wrr(`PXR_CMD_CONF2, {4'h3, 1'h0, c, 4'h0, c[1:0], 2'h0});
			chk("current", {13'h0000, c}, {13'h0000, emitter_current_o});
			chk("pulses", {14'h0000, c[1:0]}, {14'h0000, pulse_count_o});
			chk("sens", 16'h0003, {14'h0000, high_sensitivity_o, crosstalk_cancel_o});
		end
		rdc(`PXR_CMD_CONF2, 16'h370C);
		wrr(`PXR_CMD_CONF1, 16'h0080);
		chk("calibration", 16'h0001, {15'h0000, calibration_enable_o});
		wrr(`PXR_CMD_CONF3, 16'h1C00);
		chk("ambient", 16'h0001, {15'h0000, ambient_cancel_o});
		wrr(`PXR_CMD_CONF3, 16'h0010);
		chk("ambient off", 16'h0000, {15'h0000, ambient_cancel_o});
		$display("test fields done");
		meas(16'h0001, 16'h0000, 16'h0000, 16'h9000, 16'h0FFF);
		meas(16'h4001, 16'h0000, 16'h0000, 16'h5000, 16'h0FFF);
		meas(16'h4001, 16'h0033, 16'h0000, 16'hFFFF, 16'hFFFF);
		meas(16'h0001, 16'h0000, 16'h0100, 16'h0300, 16'h0200);
		$display("test measurement done");
		wrr(`PXR_CMD_THHI, 16'h0100);
		meas(16'h2301, 16'h0000, 16'h0000, 16'h0200, 16'h0200);
		chk("irq near", 16'h0001, {15'h0000, irq_oe_o});
		rdc(`PXR_CMD_FLAGS, 16'h0200);
		chk("irq clear", 16'h0000, {15'h0000, irq_oe_o});
		glare_event_i <= 1'h1;
		@(posedge mclk_i);
		glare_event_i <= 1'h0;
		repeat (4) @(posedge mclk_i);
		chk("irq glare", 16'h0001, {15'h0000, irq_oe_o});
		rdc(`PXR_CMD_FLAGS, 16'h1000);
		// Logic mode: pin follows the near state, not the flags
		wrr(`PXR_CMD_CONF1, 16'h0101);
		chk("irq level", 16'h0001, {15'h0000, irq_oe_o});
		rdc(`PXR_CMD_FLAGS, 16'h0000);
		chk("irq level held", 16'h0001, {15'h0000, irq_oe_o});
		$display("test interrupt done");
		results();
	end
endmodule
